// ---- hdl/sai_defs.svh ----
// Register map, field positions, reset values and timing limits in ns and Hz
// Assumes a 25 MHz system clock; included by bare name
`ifndef SAI_DEFS_SVH
`define SAI_DEFS_SVH

`define SAI_ADDR_FORMAT      8'h33
`define SAI_ADDR_OFFSET      8'h34
`define SAI_ADDR_AGAIN       8'h54
`define SAI_ADDR_STATUS      8'h71

`define SAI_FORMAT_RST       8'h02
`define SAI_OFFSET_RST       8'h00
`define SAI_AGAIN_RST        8'h00
`define SAI_DGAIN_0DB        8'h00

`define SAI_FMT_MSB          5
`define SAI_FMT_LSB          4
`define SAI_SHORT_FS_MSB     3
`define SAI_SHORT_FS_LSB     2
`define SAI_WLEN_MSB         1
`define SAI_WLEN_LSB         0
`define SAI_OFFSET_HI_BIT    7
`define SAI_AGAIN_MSB        4

`define SAI_ST_ERR           0
`define SAI_ST_HALT          1
`define SAI_ST_RATE_LSB      2
`define SAI_ST_RATE_MSB      3

`define SAI_WLEN_16          6'h10
`define SAI_WLEN_20          6'h14
`define SAI_WLEN_24          6'h18
`define SAI_WLEN_32          6'h20

`define SAI_RATIO_32         10'h020
`define SAI_RATIO_64         10'h040
`define SAI_RATIO_128        10'h080
`define SAI_RATIO_256        10'h100
`define SAI_RATIO_512        10'h200

`define SAI_CLK_HZ           25000000
`define SAI_HALT_NS          10000
`define SAI_RATE_CHANGE_NS   100000
`define SAI_FS_MIN_HZ        28000
`define SAI_FS_32_48_HZ      38000
`define SAI_FS_48_96_HZ      70000
`define SAI_FS_MAX_HZ        110000

`endif

// ---- hdl/sai_pkg.sv ----
// Types shared by the serial audio input port and its users
// Pure type definitions, no logic
package sai_pkg;

    typedef enum logic [1:0] {
        FMT_I2S,
        FMT_LJ,
        FMT_RJ,
        FMT_TDM
    } sai_fmt_e;

    typedef enum logic [1:0] {
        RATE_NONE,
        RATE_32K,
        RATE_48K,
        RATE_96K
    } sai_rate_e;

    typedef enum logic [1:0] {
        LINK_HALTED,
        LINK_ACQUIRE,
        LINK_RUN
    } sai_link_e;

    typedef logic [31:0] sai_sample_t;

endpackage : sai_pkg

// ---- hdl/sai_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin inputs
// Assumes the bits are independent levels; no bus coherence
`timescale 1ns/1ps
module sai_sync #(
    parameter int W = 3
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : sai_sync

// ---- hdl/sai_pwm.sv ----
// Two-channel complementary PWM modulator
// Assumes offset-binary duty codes loaded once per stereo sample
`timescale 1ns/1ps
module sai_pwm #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_duty_a,
    input  wire logic [W-1:0] i_duty_b,
    output logic      [3:0]   o_pwm
);
    logic [W-1:0] carrier;
    logic [W-1:0] duty_a;
    logic [W-1:0] duty_b;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            carrier <= '0;
        end else begin
            carrier <= carrier + 1'b1;
        end
    end

    // Mid-scale duty after reset keeps both bridge halves balanced
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            duty_a <= {1'b1, {(W-1){1'b0}}};
            duty_b <= {1'b1, {(W-1){1'b0}}};
        end else if (i_load) begin
            duty_a <= i_duty_a;
            duty_b <= i_duty_b;
        end
    end

    // Order: A+, A-, B+, B-
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pwm <= 4'h0;
        end else begin
            o_pwm[0] <= (carrier < duty_a);
            o_pwm[1] <= ~(carrier < duty_a);
            o_pwm[2] <= (carrier < duty_b);
            o_pwm[3] <= ~(carrier < duty_b);
        end
    end
endmodule : sai_pwm

// ---- hdl/sai_port.sv ----
// Serial audio input port: receiver, rate detect, clock-error handling,
// format and gain registers, and the stereo PWM stage it feeds.
// Assumes bit clock, word select and data arrive from an external master
// asynchronous to i_clk and much slower than it.
`timescale 1ns/1ps
`include "sai_defs.svh"
module sai_port #(
    parameter int PWM_W = 8
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_bclk,
    input  wire logic                   i_word_select_frame_sync,
    input  wire logic                   i_serial_data_input,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [7:0]             i_reg_addr,
    input  wire logic [7:0]             i_reg_wdata,
    output logic      [7:0]             o_reg_rdata,
    output sai_pkg::sai_sample_t        o_left,
    output sai_pkg::sai_sample_t        o_right,
    output logic                        o_sample_valid,
    output sai_pkg::sai_rate_e          o_rate,
    output logic                        o_pll_locked,
    output logic                        o_clock_error,
    output logic      [4:0]             o_analog_gain,
    output logic      [7:0]             o_digital_gain,
    output logic      [3:0]             o_pwm,
    output logic      [3:0]             o_pwm_oe
);
    import sai_pkg::*;

    localparam int HALT_CYC = (`SAI_HALT_NS * (`SAI_CLK_HZ / 1000000)) / 1000;
    localparam int MAX_CYC  = `SAI_CLK_HZ / `SAI_FS_MIN_HZ;
    localparam int C32_48   = `SAI_CLK_HZ / `SAI_FS_32_48_HZ;
    localparam int C48_96   = `SAI_CLK_HZ / `SAI_FS_48_96_HZ;
    localparam int MIN_CYC  = `SAI_CLK_HZ / `SAI_FS_MAX_HZ;
    localparam int IDLE_W   = $clog2(HALT_CYC + 1);

    logic [7:0]          format_reg;
    logic [7:0]          offset_reg;
    logic [7:0]          again_reg;
    logic [7:0]          status;
    logic [2:0]          sy;
    logic                bclk_d;
    logic                bclk_rise;
    logic                bclk_edge;
    logic                ws_prev;
    logic                ws_bound;
    logic                frame_start;
    logic [IDLE_W-1:0]   idle_cnt;
    logic                halted;
    logic [10:0]         frame_clk;
    logic [9:0]          frame_bits;
    logic                frame_lost;
    logic                frame_good;
    sai_rate_e           frame_rate;
    sai_link_e           link;
    sai_fmt_e            fmt;
    logic [5:0]          wlen;
    logic [10:0]         offs;
    logic [10:0]         start;
    logic [10:0]         cur_idx;
    logic [9:0]          bit_idx;
    logic                in_word;
    logic                first_bit;
    logic                last_bit;
    logic                to_right;
    logic [31:0]         acc;
    logic [31:0]         next_acc;
    logic [31:0]         rj_sr;
    logic [5:0]          align;
    logic                load_pwm;

    assign fmt = sai_fmt_e'(format_reg[`SAI_FMT_MSB:`SAI_FMT_LSB]);

    // Register writes; status is read-only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            format_reg <= `SAI_FORMAT_RST;
            offset_reg <= `SAI_OFFSET_RST;
            again_reg  <= `SAI_AGAIN_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `SAI_ADDR_FORMAT) begin
                format_reg <= i_reg_wdata;
            end else if (i_reg_addr == `SAI_ADDR_OFFSET) begin
                offset_reg <= i_reg_wdata;
            end else if (i_reg_addr == `SAI_ADDR_AGAIN) begin
                again_reg <= i_reg_wdata;
            end
        end
    end

    always_comb begin
        status = 8'h00;
        status[`SAI_ST_ERR]  = (link != LINK_RUN);
        status[`SAI_ST_HALT] = halted;
        status[`SAI_ST_RATE_MSB:`SAI_ST_RATE_LSB] = o_rate;
    end

    // Registered read; unmapped addresses return zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (i_reg_addr == `SAI_ADDR_FORMAT) begin
                o_reg_rdata <= format_reg;
            end else if (i_reg_addr == `SAI_ADDR_OFFSET) begin
                o_reg_rdata <= offset_reg;
            end else if (i_reg_addr == `SAI_ADDR_AGAIN) begin
                o_reg_rdata <= again_reg;
            end else if (i_reg_addr == `SAI_ADDR_STATUS) begin
                o_reg_rdata <= status;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_analog_gain  <= 5'h00;
            o_digital_gain <= `SAI_DGAIN_0DB;
        end else begin
            o_analog_gain  <= again_reg[`SAI_AGAIN_MSB:0];
            o_digital_gain <= `SAI_DGAIN_0DB;
        end
    end

    sai_sync #(
        .W (3)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_bclk, i_word_select_frame_sync, i_serial_data_input}),
        .o_q   (sy)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bclk_d <= 1'b0;
        end else begin
            bclk_d <= sy[2];
        end
    end

    assign bclk_rise   = sy[2] & ~bclk_d;
    assign bclk_edge   = sy[2] ^ bclk_d;
    assign ws_bound    = bclk_rise & (sy[1] != ws_prev);
    assign frame_start = bclk_rise & sy[1] & ~ws_prev;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ws_prev <= 1'b0;
        end else if (bclk_rise) begin
            ws_prev <= sy[1];
        end
    end

    // Halt seen when the bit clock stops toggling in either level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idle_cnt <= '0;
        end else if (bclk_edge) begin
            idle_cnt <= '0;
        end else if (!halted) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    assign halted = (idle_cnt == IDLE_W'(HALT_CYC));

    // Frame timing in system clocks and bit clocks, saturating
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            frame_clk  <= 11'h7FF;
            frame_bits <= 10'h000;
        end else begin
            if (frame_start) begin
                frame_clk <= 11'h000;
            end else if (frame_clk != 11'h7FF) begin
                frame_clk <= frame_clk + 1'b1;
            end
            if (frame_start) begin
                frame_bits <= 10'h001;
            end else if (bclk_rise && frame_bits != 10'h3FF) begin
                frame_bits <= frame_bits + 1'b1;
            end
        end
    end

    // Frame sync stuck while bit clock runs counts as halted clocks
    assign frame_lost = halted || (frame_clk > 11'(MAX_CYC));

    always_comb begin
        if (frame_clk > 11'(MAX_CYC) || frame_clk < 11'(MIN_CYC)) begin
            frame_rate = RATE_NONE;
        end else if (frame_clk > 11'(C32_48)) begin
            frame_rate = RATE_32K;
        end else if (frame_clk > 11'(C48_96)) begin
            frame_rate = RATE_48K;
        end else begin
            frame_rate = RATE_96K;
        end
    end

    always_comb begin
        frame_good = 1'b0;
        if (frame_rate != RATE_NONE) begin
            if (fmt != FMT_TDM) begin
                frame_good = (frame_bits == `SAI_RATIO_32)
                          || (frame_bits == `SAI_RATIO_64);
            end else begin
                frame_good = (frame_bits == `SAI_RATIO_128)
                          || (frame_bits == `SAI_RATIO_256
                              && frame_rate != RATE_32K)
                          || (frame_bits == `SAI_RATIO_512
                              && frame_rate == RATE_48K);
            end
        end
    end

    // Two good frames in a row before the outputs are released
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            link <= LINK_HALTED;
        end else begin
            case (link)
                LINK_HALTED: begin
                    if (!frame_lost && frame_start && frame_good) begin
                        link <= LINK_ACQUIRE;
                    end
                end
                LINK_ACQUIRE: begin
                    if (frame_lost) begin
                        link <= LINK_HALTED;
                    end else if (frame_start) begin
                        link <= frame_good ? LINK_RUN : LINK_HALTED;
                    end
                end
                LINK_RUN: begin
                    if (frame_lost || (frame_start && !frame_good)) begin
                        link <= LINK_HALTED;
                    end
                end
                default: begin
                    link <= LINK_HALTED;
                end
            endcase
        end
    end

    // Config registers are untouched by a halt, so recovery is automatic
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pwm_oe      <= 4'h0;
            o_pll_locked  <= 1'b0;
            o_clock_error <= 1'b1;
            o_rate        <= RATE_NONE;
        end else begin
            o_pwm_oe      <= {4{link == LINK_RUN}};
            o_pll_locked  <= (link == LINK_RUN);
            o_clock_error <= (link != LINK_RUN);
            if (frame_lost) begin
                o_rate <= RATE_NONE;
            end else if (frame_start && frame_good) begin
                o_rate <= frame_rate;
            end
        end
    end

    always_comb begin
        case (format_reg[`SAI_WLEN_MSB:`SAI_WLEN_LSB])
            2'h0:    wlen = `SAI_WLEN_16;
            2'h1:    wlen = `SAI_WLEN_20;
            2'h2:    wlen = `SAI_WLEN_24;
            default: wlen = `SAI_WLEN_32;
        endcase
    end

    assign offs    = {2'h0, format_reg[`SAI_OFFSET_HI_BIT], offset_reg};
    assign start   = offs + {10'h000, fmt == FMT_I2S};
    assign cur_idx = ((fmt == FMT_TDM) ? frame_start : ws_bound)
                   ? 11'h000 : {1'b0, bit_idx};
    assign align   = `SAI_WLEN_32 - wlen;

    // Slot window; bits past the word length are dropped
    always_comb begin
        if (fmt == FMT_TDM) begin
            in_word   = cur_idx >= offs && cur_idx < offs + {wlen, 1'b0};
            to_right  = cur_idx >= offs + {5'h00, wlen};
            first_bit = cur_idx == offs
                     || cur_idx == offs + {5'h00, wlen};
            last_bit  = cur_idx == offs + {5'h00, wlen} - 11'h001
                     || cur_idx == offs + {wlen, 1'b0} - 11'h001;
        end else begin
            in_word   = cur_idx >= start
                     && cur_idx < start + {5'h00, wlen};
            to_right  = (fmt == FMT_I2S) ? sy[1] : ~sy[1];
            first_bit = cur_idx == start;
            last_bit  = cur_idx == start + {5'h00, wlen} - 11'h001;
        end
        next_acc = first_bit ? {31'h0, sy[0]} : {acc[30:0], sy[0]};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bit_idx <= 10'h000;
            acc     <= 32'h0;
            rj_sr   <= 32'h0;
        end else if (bclk_rise) begin
            bit_idx <= 10'(cur_idx + 11'h001);
            rj_sr   <= {rj_sr[30:0], sy[0]};
            if (in_word) begin
                acc <= next_acc;
            end
        end
    end

    // Samples left-aligned in 32 bits; right-justified data is taken
    // from the bits before the word-select change
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_left         <= 32'h0;
            o_right        <= 32'h0;
            o_sample_valid <= 1'b0;
            load_pwm       <= 1'b0;
        end else begin
            o_sample_valid <= 1'b0;
            load_pwm       <= 1'b0;
            if (fmt == FMT_RJ) begin
                if (ws_bound && ws_prev) begin
                    o_left <= rj_sr << align;
                end else if (ws_bound) begin
                    o_right        <= rj_sr << align;
                    o_sample_valid <= (link == LINK_RUN);
                    load_pwm       <= 1'b1;
                end
            end else if (bclk_rise && in_word && last_bit) begin
                if (to_right) begin
                    o_right        <= next_acc << align;
                    o_sample_valid <= (link == LINK_RUN);
                    load_pwm       <= 1'b1;
                end else begin
                    o_left <= next_acc << align;
                end
            end
        end
    end

    sai_pwm #(
        .W (PWM_W)
    ) u_pwm (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_load   (load_pwm),
        .i_duty_a ({~o_left[31], o_left[30:32-PWM_W]}),
        .i_duty_b ({~o_right[31], o_right[30:32-PWM_W]}),
        .o_pwm    (o_pwm)
    );

endmodule : sai_port

// ---- bench/sai_port_checker.sv ----
// Port assertions for the serial audio input port
// Bound to sai_port from the bench top file; sees its ports only
`timescale 1ns/1ps
module sai_port_checker (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_bclk,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_sample_valid,
    input wire logic       o_pll_locked,
    input wire logic       o_clock_error,
    input wire logic [4:0] o_analog_gain,
    input wire logic [7:0] o_digital_gain,
    input wire logic [3:0] o_pwm,
    input wire logic [3:0] o_pwm_oe
);
    logic       bclk_q;
    logic [8:0] idle_cnt;
    logic [4:0] gain_w;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Raw pin idle time; design sees it two flops later
    always_ff @(posedge i_clk) begin
        bclk_q <= i_bclk;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst || bclk_q != i_bclk) begin
            idle_cnt <= 9'h000;
        end else if (idle_cnt != 9'h1FF) begin
            idle_cnt <= idle_cnt + 9'h001;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reg_wr && i_reg_addr == 8'h54) begin
            gain_w <= i_reg_wdata[4:0];
        end
    end

    a_lock_vs_error: assert property (o_pll_locked != o_clock_error)
        else $error("lock and clock error agree");
    a_oe_with_lock: assert property (
        o_pwm_oe == {4{o_pll_locked}})
        else $error("output enables differ from lock");
    a_halt_hiz: assert property (
        idle_cnt > 9'h10E |-> o_pwm_oe == 4'h0 && o_clock_error)
        else $error("outputs driven while bit clock halted");
    a_valid_pulse: assert property (
        o_sample_valid |-> o_pll_locked ##1 !o_sample_valid)
        else $error("sample valid outside run or too long");
    a_dgain_zero: assert property (o_digital_gain == 8'h00)
        else $error("digital gain not 0 dB");
    a_gain_write: assert property (
        i_reg_wr && i_reg_addr == 8'h54 |-> ##[1:3] o_analog_gain == gain_w)
        else $error("analog gain not taken from write");
    a_unmapped_zero: assert property (
        i_reg_rd && !i_reg_wr
        && !(i_reg_addr inside {8'h33, 8'h34, 8'h54, 8'h71})
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_pwm_pairs: assert property (
        o_pwm_oe == 4'hF |-> o_pwm[1] == !o_pwm[0] && o_pwm[3] == !o_pwm[2])
        else $error("pwm pair not complementary");
endmodule : sai_port_checker

// ---- bench/sai_host_model.sv ----
// Host model: serial audio clock master driving bit clock, word select
// and data; clocks stand still between calls, spare bits toggle
`timescale 1ns/1ps
module sai_host_model (
    output logic o_bclk,
    output logic o_ws,
    output logic o_sd
);
    initial begin
        o_bclk = 1'b0;
        o_ws   = 1'b0;
        o_sd   = 1'b0;
    end

    // fmt 0 I2S, 1 LJ, 2 RJ, 3 TDM; h is half a frame in bits
    task automatic send(input int fmt, input int h, input int wl,
                        input int off, input int hp, input logic [31:0] l,
                        input logic [31:0] r, input int n);
        int          k;
        logic [31:0] w;
        #13;
        repeat (n) begin
            for (int i = 0; i < 2 * h; i++) begin
                w = (i < h) ? l : r;
                k = i % h - off - ((fmt == 0) ? 1 : (fmt == 2) ? h - wl : 0);
                if (fmt == 3) begin
                    k = i - off;
                    w = l;
                    if (k >= wl) begin
                        k = k - wl;
                        w = r;
                    end
                end
                o_bclk = 1'b0;
                o_ws = (fmt == 0) ? (i >= h)
                     : (fmt == 3) ? (i == 0) : (i < h);
                o_sd = (k >= 0 && k < wl) ? w[31 - k] : !o_sd;
                #(hp);
                o_bclk = 1'b1;
                #(hp);
            end
        end
    endtask : send
endmodule : sai_host_model

// ---- bench/tb_sai_port.sv ----
// Top bench for the serial audio input port with host model
// Assumes sai_pkg and the design files are compiled first
`timescale 1ns/1ps
module tb_sai_port;
    import sai_pkg::*;

    logic        i_clk, i_rst, i_reg_wr, i_reg_rd;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_digital_gain;
    sai_sample_t o_left, o_right;
    sai_rate_e   o_rate;
    logic        o_sample_valid, o_pll_locked, o_clock_error;
    logic [4:0]  o_analog_gain;
    logic [3:0]  o_pwm, o_pwm_oe;
    wire         i_bclk, i_word_select_frame_sync, i_serial_data_input;
    int          n_mismatch, comparisons, cyc, nv;
    logic [31:0] seed, l, r, mask, exp_l, exp_r;
    // Per run: format, half bits, word code, offset, half period, rate
    int          fm[7] = '{0, 1, 2, 1, 3, 0, 3};
    int          hb[7] = '{32, 32, 32, 16, 64, 32, 64};
    int          wc[7] = '{2, 3, 1, 0, 2, 0, 0};
    int          of[7] = '{0, 0, 0, 0, 0, 2, 0};
    int          hp[7] = '{160, 160, 160, 160, 80, 160, 120};
    int          rt[7] = '{2, 2, 2, 3, 2, 2, 1};
    int          wbits[4] = '{16, 20, 24, 32};
    logic [7:0]  f33[7] = '{8'h02, 8'h13, 8'h21, 8'h10, 8'h36, 8'h00, 8'h34};

    sai_port u_dut (.i_clk, .i_rst, .i_bclk, .i_word_select_frame_sync,
        .i_serial_data_input, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .o_reg_rdata, .o_left, .o_right, .o_sample_valid,
        .o_rate, .o_pll_locked, .o_clock_error, .o_analog_gain,
        .o_digital_gain, .o_pwm, .o_pwm_oe);
    sai_host_model u_host (.o_bclk(i_bclk), .o_ws(i_word_select_frame_sync),
        .o_sd(i_serial_data_input));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    // Read data holds until the next read, so a late sample is safe
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        check(o_reg_rdata & m, e);
        @(posedge i_clk);
    endtask : rd

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    always @(negedge i_clk) begin
        if (o_sample_valid === 1'b1) begin
            nv++;
            check(o_left, exp_l);
            check(o_right, exp_r);
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        i_rst = 1'b1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        seed = 32'h98D9CADF;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(8'h33, 8'hFF, 8'h02);
        rd(8'h34, 8'hFF, 8'h00);
        rd(8'h10, 8'hFF, 8'h00);
        wr(8'h71, 8'hFE);
        rd(8'h71, 8'h01, 8'h01);
        check(o_digital_gain, 8'h00);
        check(o_pwm_oe, 4'h0);
        rd(8'h54, 8'hFF, 8'h00);
        wr(8'h54, 8'h1F);
        repeat (3) @(posedge i_clk);
        check(o_analog_gain, 5'h1F);
        for (int t = 0; t < 7; t++) begin
            l = xs(seed);
            r = xs(l);
            seed = r;
            mask = ~(32'hFFFFFFFF >> wbits[wc[t]]);
            if (t > 0) begin
                wr(8'h33, f33[t]);
                wr(8'h34, 8'(of[t]));
            end
            exp_l = l & mask;
            exp_r = r & mask;
            nv = 0;
            u_host.send(fm[t], hb[t], wbits[wc[t]], of[t], hp[t], l, r, 6);
            @(posedge i_clk);
            check(32'(nv > 0), 32'h1);
            check(o_pll_locked, 1'b1);
            check(o_rate, 32'(rt[t]));
            check(o_pwm_oe, 4'hF);
            rd(8'h71, 8'hFF, 8'(rt[t] * 4));
            repeat (2600) @(posedge i_clk);
            check(o_pwm_oe, 4'h0);
            rd(8'h71, 8'h03, 8'h03);
        end
        // Unsupported 48 bits per frame must never lock
        wr(8'h33, 8'h00);
        u_host.send(0, 24, 16, 0, 160, l, r, 6);
        @(posedge i_clk);
        check(o_clock_error, 1'b1);
        check(o_pwm_oe, 4'h0);
        results();
    end
endmodule : tb_sai_port

bind sai_port sai_port_checker u_chk (.i_clk, .i_rst, .i_bclk, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_sample_valid,
    .o_pll_locked, .o_clock_error, .o_analog_gain, .o_digital_gain,
    .o_pwm, .o_pwm_oe);
